// >>> inc/router_pkg.sv
// Shared constants and types for the split-bus address router.
package router_pkg;
  localparam int NUM_MASTERS = 2;
  localparam int NUM_SLAVES  = 4;
  // Slave port indices.
  localparam int SLV_EXT    = 0;
  localparam int SLV_SDRAM  = 1;
  localparam int SLV_SRAM   = 2;
  localparam int SLV_PERIPH = 3;
  // Address windows, by the top nibble of the address.
  localparam logic [3:0] NIB_EXT_LO_TOP = 4'h3;
  localparam logic [3:0] NIB_SDRAM_BOT  = 4'h4;
  localparam logic [3:0] NIB_SDRAM_TOP  = 4'h7;
  localparam logic [3:0] NIB_SRAM       = 4'h8;
  localparam logic [3:0] NIB_EXT_HI_BOT = 4'hC;
  localparam logic [3:0] NIB_EXT_HI_TOP = 4'hD;
  localparam logic [3:0] NIB_PERIPH     = 4'hF;
  // Chip-select port width codes.
  localparam logic [1:0] PW_32 = 2'h0;
  localparam logic [1:0] PW_8  = 2'h1;
  localparam logic [1:0] PW_16 = 2'h2;
  // Data lane ownership: bit 1 is D[31:16], bit 0 is D[15:0].
  localparam logic [1:0] LANES_ALL = 2'h3;
  localparam logic [1:0] LANES_HI  = 2'h2;
  localparam logic [1:0] LANES_LO  = 2'h1;
  localparam logic [1:0] LANES_RST = 2'h3;
  localparam logic       SPLIT_RST = 1'h0;
  localparam logic [1:0] PW_RST    = 2'h0;
  localparam logic       ARB_FIXED = 1'h0;
  typedef enum logic {ARB_IDLE = 1'b0, ARB_BUSY = 1'b1} arb_state_t;
  typedef enum logic [1:0] {
    STRAP_WAIT1 = 2'b00,
    STRAP_WAIT2 = 2'b01,
    STRAP_TAKE  = 2'b11,
    STRAP_DONE  = 2'b10
  } strap_state_t;
endpackage

// >>> inc/xbar_if.sv
// Link between the router and one per-slave arbiter.
`timescale 1ns/1ps
`default_nettype none
interface xbar_if;
  logic [1:0] req;
  logic       mode;
  logic       prio;
  logic       done;
  logic [1:0] grant_d;
  logic [1:0] grant_q;
  modport arb (input req, input mode, input prio, input done,
               output grant_d, output grant_q);
  modport xbar (output req, output mode, output prio, output done,
                input grant_d, input grant_q);
endinterface
`default_nettype wire

// >>> hdl/slave_arbiter.sv
// Two-master arbiter for one slave port, fixed or round-robin.
`timescale 1ns/1ps
`default_nettype none
module slave_arbiter (
  input  wire logic sys_clk, // System bus clock.
  input  wire logic rst,     // Asynchronous reset, active high.
  xbar_if.arb       lnk      // Requests in, grants out.
);
  router_pkg::arb_state_t state_q;
  router_pkg::arb_state_t state_d;
  logic [1:0] grant_q;
  logic [1:0] grant_d;
  logic       last_q;
  logic       last_d;
  logic       pref;
  logic       pick;

  always_comb begin
    state_d = state_q;
    grant_d = grant_q;
    last_d  = last_q;
    // Round robin favours the master not served last.
    pref = (lnk.mode == router_pkg::ARB_FIXED) ? lnk.prio : ~last_q;
    pick = lnk.req[pref] ? pref : ~pref;
    case (state_q)
      router_pkg::ARB_IDLE: begin
        if (|lnk.req) begin
          grant_d = 2'h1 << pick;
          last_d  = pick;
          state_d = router_pkg::ARB_BUSY;
        end
      end
      router_pkg::ARB_BUSY: begin
        if (lnk.done) begin
          grant_d = 2'h0;
          state_d = router_pkg::ARB_IDLE;
        end
      end
      default: begin
        grant_d = 2'h0;
        state_d = router_pkg::ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= router_pkg::ARB_IDLE;
      grant_q <= 2'h0;
      last_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      grant_q <= grant_d;
      last_q  <= last_d;
    end
  end

  assign lnk.grant_d = grant_d;
  assign lnk.grant_q = grant_q;

  property p_grant_onehot;
    @(posedge sys_clk) disable iff (rst) $onehot0(grant_q);
  endproperty
  a_grant_onehot: assert property (p_grant_onehot) else $error("two grants on one slave");

  property p_fixed_pick;
    @(posedge sys_clk) disable iff (rst)
      (state_q == router_pkg::ARB_IDLE && lnk.req == 2'h3 && lnk.mode == router_pkg::ARB_FIXED)
      |=> grant_q[$past(lnk.prio)];
  endproperty
  a_fixed_pick: assert property (p_fixed_pick) else $error("fixed priority not honoured");

  property p_rr_pick;
    @(posedge sys_clk) disable iff (rst)
      (state_q == router_pkg::ARB_IDLE && lnk.req == 2'h3 && lnk.mode != router_pkg::ARB_FIXED)
      |=> grant_q[~$past(last_q)];
  endproperty
  a_rr_pick: assert property (p_rr_pick) else $error("round robin did not rotate");

  property p_grant_hold;
    @(posedge sys_clk) disable iff (rst)
      (state_q == router_pkg::ARB_BUSY && !lnk.done) |=> $stable(grant_q);
  endproperty
  a_grant_hold: assert property (p_grant_hold) else $error("grant moved mid transfer");

  c_contend: cover property (@(posedge sys_clk) disable iff (rst)
    state_q == router_pkg::ARB_IDLE && lnk.req == 2'h3);
endmodule
`default_nettype wire

// >>> hdl/split_bus_address_router.sv
// Crossbar address router with split/shared external data bus mode.
// Summary of operation
// - The bus-select strap is sampled after reset and picks shared 32-bit or split 16-bit mode.
// - Split mode gives D[31:16] to SDRAM and D[15:0] to the external bus; shared gives all.
// - In shared mode the external bus passes 32, 16 and 8-bit chip-select widths.
// - In split mode the external bus offers only 16 and 8-bit chip-select widths.
// - Masters reaching different slaves proceed in the same cycle without interference.
// - Masters contending for one slave are arbitrated and granted one at a time.
// - Arbitration method and priority are set separately for each slave port.
// - 0x0-0x3FFFFFFF goes to external bus, 0x4.. to SDRAM, 0x8.. to on-chip SRAM.
// - 0xC0000000-0xDFFFFFFF also goes to the external bus, for non-memory devices.
// - 0x90000000-0xBFFFFFFF and 0xE0000000-0xEFFFFFFF are reserved with no slave.
// - The top 256 MB goes to the peripheral register space.
// - The peripheral window is fixed; memory windows never leave their own ranges.
`timescale 1ns/1ps
`default_nettype none
module split_bus_address_router (
  input  wire logic                   sys_clk,               // System bus clock.
  input  wire logic                   rst,                   // Async reset, high.
  input  wire logic                   dram_bus_select_strap, // Pin: 1 = split.
  input  wire logic [1:0]             cs_port_width,         // Chip-select width.
  input  wire logic [3:0]             arb_mode,              // Per slave: 1 = rr.
  input  wire logic [3:0]             arb_prio,              // Per slave fixed win.
  input  wire logic [1:0]             m_req,                 // Master requests.
  input  wire logic [1:0][31:0]       m_addr,                // Master addresses.
  input  wire logic [1:0]             m_wr,                  // Master write flags.
  output logic      [1:0]             m_ack_q,               // Done pulse.
  output logic      [1:0]             m_err_q,               // Error pulse.
  input  wire logic [3:0]             s_done,                // Slave finished.
  output logic      [3:0]             s_sel_q,               // Slave selected.
  output logic      [3:0][31:0]       s_addr_q,              // Slave address.
  output logic      [3:0]             s_wr_q,                // Slave write flag.
  output logic      [3:0]             s_mid_q,               // Granted master.
  output logic                        split_mode_q,          // Split bus mode.
  output logic      [1:0]             sdram_lanes_q,         // SDRAM data lanes.
  output logic      [1:0]             ext_lanes_q,           // Ext data lanes.
  output logic      [1:0]             ext_port_width_q       // Effective width.
);
  localparam int NM = router_pkg::NUM_MASTERS;
  localparam int NS = router_pkg::NUM_SLAVES;

  // Strap capture.
  logic                      strap_meta_q;
  logic                      strap_sync_q;
  router_pkg::strap_state_t  strap_st_q;
  router_pkg::strap_state_t  strap_st_d;
  logic                      split_mode_d;
  logic [1:0]                sdram_lanes_d;
  logic [1:0]                ext_lanes_d;
  logic [1:0]                ext_port_width_d;

  // Routing.
  logic [NM-1:0][NS-1:0]     hit;
  logic [NM-1:0]             rsvd;
  logic [NS-1:0][NM-1:0]     slv_req;
  logic [NS-1:0][NM-1:0]     slv_gnt_d;
  logic [NM-1:0]             m_ack_d;
  logic [NM-1:0]             m_err_d;
  logic [NS-1:0]             s_sel_d;
  logic [NS-1:0][31:0]       s_addr_d;
  logic [NS-1:0]             s_wr_d;
  logic [NS-1:0]             s_mid_d;

  function automatic logic [4:0] route(input logic [31:0] a);
    logic [3:0] nib;
    logic [4:0] r;
    nib = a[31:28];
    r   = 5'h10;
    if (nib <= router_pkg::NIB_EXT_LO_TOP) begin
      r = 5'h01 << router_pkg::SLV_EXT;
    end else if (nib >= router_pkg::NIB_SDRAM_BOT && nib <= router_pkg::NIB_SDRAM_TOP) begin
      r = 5'h01 << router_pkg::SLV_SDRAM;
    end else if (nib == router_pkg::NIB_SRAM) begin
      r = 5'h01 << router_pkg::SLV_SRAM;
    end else if (nib >= router_pkg::NIB_EXT_HI_BOT && nib <= router_pkg::NIB_EXT_HI_TOP) begin
      r = 5'h01 << router_pkg::SLV_EXT;
    end else if (nib == router_pkg::NIB_PERIPH) begin
      // Hard-wired: the register space cannot be moved.
      r = 5'h01 << router_pkg::SLV_PERIPH;
    end
    // Anything else is a reserved gap and keeps bit 4 alone.
    return r;
  endfunction

  // Strap: two flops, then one capture and never again until reset.
  always_comb begin
    strap_st_d       = strap_st_q;
    split_mode_d     = split_mode_q;
    case (strap_st_q)
      router_pkg::STRAP_WAIT1: strap_st_d = router_pkg::STRAP_WAIT2;
      router_pkg::STRAP_WAIT2: strap_st_d = router_pkg::STRAP_TAKE;
      router_pkg::STRAP_TAKE: begin
        split_mode_d = strap_sync_q;
        strap_st_d   = router_pkg::STRAP_DONE;
      end
      router_pkg::STRAP_DONE: strap_st_d = router_pkg::STRAP_DONE;
      default: strap_st_d = router_pkg::STRAP_WAIT1;
    endcase
    if (split_mode_d) begin
      sdram_lanes_d = router_pkg::LANES_HI;
      ext_lanes_d   = router_pkg::LANES_LO;
    end else begin
      sdram_lanes_d = router_pkg::LANES_ALL;
      ext_lanes_d   = router_pkg::LANES_ALL;
    end
    // A 32-bit request in split mode is folded to 16 bits so the
    // lower half never sees an access it cannot carry.
    if (split_mode_d && cs_port_width == router_pkg::PW_32) begin
      ext_port_width_d = router_pkg::PW_16;
    end else begin
      ext_port_width_d = cs_port_width;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_meta_q     <= 1'b0;
      strap_sync_q     <= 1'b0;
      strap_st_q       <= router_pkg::STRAP_WAIT1;
      split_mode_q     <= router_pkg::SPLIT_RST;
      sdram_lanes_q    <= router_pkg::LANES_RST;
      ext_lanes_q      <= router_pkg::LANES_RST;
      ext_port_width_q <= router_pkg::PW_RST;
    end else begin
      strap_meta_q     <= dram_bus_select_strap;
      strap_sync_q     <= strap_meta_q;
      strap_st_q       <= strap_st_d;
      split_mode_q     <= split_mode_d;
      sdram_lanes_q    <= sdram_lanes_d;
      ext_lanes_q      <= ext_lanes_d;
      ext_port_width_q <= ext_port_width_d;
    end
  end

  // Per-master decode. A request is masked while its own answer pulse
  // stands, so a held request is not served twice.
  genvar gm;
  generate
    for (gm = 0; gm < NM; gm++) begin : g_dec
      logic [4:0] r;
      assign r          = route(m_addr[gm]);
      assign hit[gm]    = r[3:0];
      assign rsvd[gm]   = r[4];
    end
  endgenerate

  // Per-slave arbiters run independently, so masters on different
  // slaves are granted in the same cycle.
  genvar gs;
  generate
    for (gs = 0; gs < NS; gs++) begin : g_slv
      xbar_if lnk ();
      for (gm = 0; gm < NM; gm++) begin : g_rq
        assign slv_req[gs][gm] = m_req[gm] & hit[gm][gs] & ~m_ack_q[gm];
      end
      assign lnk.req          = slv_req[gs];
      assign lnk.mode         = arb_mode[gs];
      assign lnk.prio         = arb_prio[gs];
      assign lnk.done         = s_done[gs] & s_sel_q[gs];
      assign slv_gnt_d[gs]    = lnk.grant_d;
      slave_arbiter u_arb (
        .sys_clk (sys_clk),
        .rst     (rst),
        .lnk     (lnk)
      );
    end
  endgenerate

  always_comb begin
    m_ack_d  = '0;
    m_err_d  = '0;
    s_sel_d  = '0;
    s_addr_d = s_addr_q;
    s_wr_d   = s_wr_q;
    s_mid_d  = s_mid_q;
    for (int s = 0; s < NS; s++) begin
      s_sel_d[s] = |slv_gnt_d[s];
      if (slv_gnt_d[s] != 2'h0 && !s_sel_q[s]) begin
        s_mid_d[s]  = slv_gnt_d[s][1];
        s_addr_d[s] = m_addr[slv_gnt_d[s][1]];
        s_wr_d[s]   = m_wr[slv_gnt_d[s][1]];
      end
      if (s_sel_q[s] && s_done[s]) begin
        m_ack_d[s_mid_q[s]] = 1'b1;
      end
    end
    for (int m = 0; m < NM; m++) begin
      // No slave sees a reserved access; the master gets an error.
      m_err_d[m] = m_req[m] & rsvd[m] & ~m_err_q[m];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      m_ack_q  <= '0;
      m_err_q  <= '0;
      s_sel_q  <= '0;
      s_addr_q <= '0;
      s_wr_q   <= '0;
      s_mid_q  <= '0;
    end else begin
      m_ack_q  <= m_ack_d;
      m_err_q  <= m_err_d;
      s_sel_q  <= s_sel_d;
      s_addr_q <= s_addr_d;
      s_wr_q   <= s_wr_d;
      s_mid_q  <= s_mid_d;
    end
  end

  property p_strap_hold;
    @(posedge sys_clk) disable iff (rst)
      strap_st_q == router_pkg::STRAP_DONE |=> $stable(split_mode_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold) else $error("bus mode changed after capture");

  property p_strap_take;
    @(posedge sys_clk) disable iff (rst)
      strap_st_q == router_pkg::STRAP_TAKE |=> split_mode_q == $past(strap_sync_q);
  endproperty
  a_strap_take: assert property (p_strap_take) else $error("strap level not captured");

  property p_lanes;
    @(posedge sys_clk) disable iff (rst)
      split_mode_q ? (sdram_lanes_q == router_pkg::LANES_HI && ext_lanes_q == router_pkg::LANES_LO)
                   : (sdram_lanes_q == router_pkg::LANES_ALL && ext_lanes_q == router_pkg::LANES_ALL);
  endproperty
  a_lanes: assert property (p_lanes) else $error("data lane ownership wrong for mode");

  property p_width_shared;
    @(posedge sys_clk) disable iff (rst)
      !split_mode_q && strap_st_q == router_pkg::STRAP_DONE
      |=> ext_port_width_q == $past(cs_port_width);
  endproperty
  a_width_shared: assert property (p_width_shared) else $error("shared width not passed");

  property p_width_split;
    @(posedge sys_clk) disable iff (rst)
      split_mode_q |-> ext_port_width_q != router_pkg::PW_32;
  endproperty
  a_width_split: assert property (p_width_split) else $error("32-bit port in split mode");

  property p_parallel;
    @(posedge sys_clk) disable iff (rst)
      (m_req == 2'h3 && !s_sel_q[router_pkg::SLV_EXT] && !s_sel_q[router_pkg::SLV_SDRAM]
       && m_ack_q == 2'h0 && hit[0][router_pkg::SLV_EXT] && hit[1][router_pkg::SLV_SDRAM])
      |=> s_sel_q[router_pkg::SLV_EXT] && s_sel_q[router_pkg::SLV_SDRAM];
  endproperty
  a_parallel: assert property (p_parallel) else $error("independent slaves not served together");

  property p_sdram_route;
    @(posedge sys_clk) disable iff (rst)
      s_sel_q[router_pkg::SLV_SDRAM] |-> s_addr_q[router_pkg::SLV_SDRAM][31:30] == 2'h1;
  endproperty
  a_sdram_route: assert property (p_sdram_route) else $error("SDRAM port got foreign address");

  property p_sram_route;
    @(posedge sys_clk) disable iff (rst)
      s_sel_q[router_pkg::SLV_SRAM]
      |-> s_addr_q[router_pkg::SLV_SRAM][31:28] == router_pkg::NIB_SRAM;
  endproperty
  a_sram_route: assert property (p_sram_route) else $error("SRAM port got foreign address");

  // The finishing edge must both answer the owner and free the port for the next master.
  property p_ack_done;
    @(posedge sys_clk) disable iff (rst)
      (s_sel_q[router_pkg::SLV_EXT] && s_done[router_pkg::SLV_EXT])
      |=> m_ack_q[$past(s_mid_q[router_pkg::SLV_EXT])] && !s_sel_q[router_pkg::SLV_EXT];
  endproperty
  a_ack_done: assert property (p_ack_done) else $error("access not acknowledged");

  property p_ext_route;
    @(posedge sys_clk) disable iff (rst)
      s_sel_q[router_pkg::SLV_EXT] |-> (s_addr_q[router_pkg::SLV_EXT][31:30] == 2'h0
                                        || s_addr_q[router_pkg::SLV_EXT][31:29] == 3'h6);
  endproperty
  a_ext_route: assert property (p_ext_route) else $error("external port got foreign address");

  property p_periph_route;
    @(posedge sys_clk) disable iff (rst)
      s_sel_q[router_pkg::SLV_PERIPH] |-> s_addr_q[router_pkg::SLV_PERIPH][31:28] == 4'hF;
  endproperty
  a_periph_route: assert property (p_periph_route) else $error("peripheral window moved");

  property p_rsvd_err;
    @(posedge sys_clk) disable iff (rst)
      (m_req[0] && rsvd[0] && !m_err_q[0]) |=> m_err_q[0] && !m_ack_q[0];
  endproperty
  a_rsvd_err: assert property (p_rsvd_err) else $error("reserved access not refused");

  property p_rsvd_nosel;
    @(posedge sys_clk) disable iff (rst)
      m_req[1] && rsvd[1] |-> slv_req == '0 || (slv_req[0][1] | slv_req[1][1]
                                | slv_req[2][1] | slv_req[3][1]) == 1'b0;
  endproperty
  a_rsvd_nosel: assert property (p_rsvd_nosel) else $error("reserved access reached a slave");

  c_both: cover property (@(posedge sys_clk) disable iff (rst) $countones(s_sel_q) >= 2);
  c_err: cover property (@(posedge sys_clk) disable iff (rst) m_err_q != 2'h0);
  c_split: cover property (@(posedge sys_clk) disable iff (rst) split_mode_q && s_sel_q[0]);
endmodule
`default_nettype wire

// >>> bench/slave_model.sv
// Behavioural model of the four slave ports that answer the router.
`timescale 1ns/1ps
`default_nettype none
module slave_model (
  input  wire logic       sys_clk, // System bus clock.
  input  wire logic       rst,     // Async reset, high.
  input  wire logic [3:0] sel,     // Slave selects from the router.
  output logic      [3:0] done     // One-cycle completion pulses.
);
  int cnt [4];
  // Slave i answers after 2*i waiting cycles, so both prompt and slow answers occur.
  // A pulse is only given while selected, and never twice for one selection.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      done <= 4'h0;
      for (int i = 0; i < 4; i++) cnt[i] <= 0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        done[i] <= 1'h0;
        if (!sel[i] || done[i]) cnt[i] <= 0;
        else if (cnt[i] == 2 * i) done[i] <= 1'h1;
        else cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/split_bus_address_router_test.sv
// Self-checking bench for the split-bus address router.
`timescale 1ns/1ps
`default_nettype none
module split_bus_address_router_test;
  logic             sys_clk = 1'h0;
  logic             rst = 1'h1;
  logic             strap = 1'h0;
  logic [1:0]       pw = 2'h0;
  logic [1:0]       m_req = 2'h0;
  logic [1:0][31:0] m_addr = '0;
  logic [1:0]       m_wr = 2'h0;
  logic [1:0]       m_ack_q;
  logic [1:0]       m_err_q;
  logic [3:0]       s_done;
  logic [3:0]       s_sel_q;
  logic [3:0][31:0] s_addr_q;
  logic [3:0]       s_wr_q;
  logic [3:0]       s_mid_q;
  logic             split_mode_q;
  logic [1:0]       sdram_lanes_q;
  logic [1:0]       ext_lanes_q;
  logic [1:0]       ext_port_width_q;
  int               error_cnt = 0;
  int               comparisons = 0;
  int               cyc = 0;
  // Window edges, the fixed peripheral base and the reserved gaps; -1 means no slave.
  logic [31:0] dec_addr [15] = '{32'h00000000, 32'h3FFFFFFF, 32'h40000000, 32'h7FFFFFFF,
    32'h80000000, 32'h8FFFFFFF, 32'hC0000000, 32'hDFFFFFFF, 32'hF0000000, 32'hFFFFFFFF,
    32'hFC000000, 32'h90000000, 32'hBFFFFFFF, 32'hE0000000, 32'hEFFFFFFF};
  int          dec_slv [15] = '{0, 0, 1, 1, 2, 2, 0, 0, 3, 3, 3, -1, -1, -1, -1};

  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) cyc <= cyc + 1;

  split_bus_address_router DUT (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .dram_bus_select_strap(strap),
    .cs_port_width        (pw),
    .arb_mode             (4'h2),
    .arb_prio             (4'h4),
    .m_req                (m_req),
    .m_addr               (m_addr),
    .m_wr                 (m_wr),
    .m_ack_q              (m_ack_q),
    .m_err_q              (m_err_q),
    .s_done               (s_done),
    .s_sel_q              (s_sel_q),
    .s_addr_q             (s_addr_q),
    .s_wr_q               (s_wr_q),
    .s_mid_q              (s_mid_q),
    .split_mode_q         (split_mode_q),
    .sdram_lanes_q        (sdram_lanes_q),
    .ext_lanes_q          (ext_lanes_q),
    .ext_port_width_q     (ext_port_width_q)
  );

  slave_model partner (
    .sys_clk(sys_clk),
    .rst    (rst),
    .sel    (s_sel_q),
    .done   (s_done)
  );

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d errors in %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // One request held until its answer; gnt is the cycle in which the slave was granted.
  task automatic access(input int m, input logic [31:0] a, input logic w, input int slv,
                        output int gnt);
    gnt = -1;
    @(negedge sys_clk);
    m_addr[m] = a;
    m_wr[m] = w;
    m_req[m] = 1'h1;
    for (int n = 0; n < 60; n++) begin
      @(posedge sys_clk);
      #1;
      if (slv >= 0 && gnt < 0 && s_sel_q[slv] && s_mid_q[slv] === m[0]) begin
        gnt = cyc;
        check("slave address", a, s_addr_q[slv]);
        check("slave write", w, s_wr_q[slv]);
      end
      if (slv < 0) check("no slave selected", 32'h0, s_sel_q);
      if (m_ack_q[m] === 1'h1 || m_err_q[m] === 1'h1) break;
    end
    check("answer", (slv < 0) ? 32'h2 : 32'h1, {m_err_q[m], m_ack_q[m]});
    if (slv >= 0) check("granted", 32'h1, gnt >= 0);
    @(negedge sys_clk);
    m_req[m] = 1'h0;
  endtask

  task automatic do_reset(input logic s);
    @(negedge sys_clk);
    rst = 1'h1;
    strap = s;
    repeat (12) @(negedge sys_clk);
    check("reset state", {router_pkg::SPLIT_RST, router_pkg::LANES_RST,
          router_pkg::LANES_RST, router_pkg::PW_RST},
          {split_mode_q, sdram_lanes_q, ext_lanes_q, ext_port_width_q});
    rst = 1'h0;
    repeat (4) @(negedge sys_clk);
  endtask

  // The strap is flipped after sampling to show that only the reset-time level counts.
  task automatic mode_and_width(input logic s);
    logic [1:0] codes [3] = '{router_pkg::PW_32, router_pkg::PW_8, router_pkg::PW_16};
    for (int k = 0; k < 2; k++) begin
      check("bus mode", {s, s ? router_pkg::LANES_HI : router_pkg::LANES_ALL,
            s ? router_pkg::LANES_LO : router_pkg::LANES_ALL},
            {split_mode_q, sdram_lanes_q, ext_lanes_q});
      strap = ~s;
      repeat (4) @(negedge sys_clk);
    end
    strap = s;
    for (int k = 0; k < 3; k++) begin
      pw = codes[k];
      repeat (2) @(negedge sys_clk);
      check("port width", (s && codes[k] == router_pkg::PW_32) ? router_pkg::PW_16 : codes[k],
            ext_port_width_q);
    end
  endtask

  // Both masters ask for one slave; the two must be granted in different cycles.
  task automatic contend(input logic [31:0] a, input int slv, output int win);
    int g0;
    int g1;
    fork
      access(0, a, 1'h0, slv, g0);
      access(1, a + 32'h4, 1'h1, slv, g1);
    join
    check("one grant at a time", 32'h1, g0 != g1);
    win = (g1 < g0) ? 1 : 0;
  endtask

  initial begin
    int g0;
    int g1;
    int w;
    do_reset(1'h0);
    mode_and_width(1'h0);
    for (int i = 0; i < 15; i++) begin
      access(i % 2, dec_addr[i], i[1], dec_slv[i], g0);
    end
    fork
      access(0, 32'h80000010, 1'h1, 2, g0);
      access(1, 32'h40000020, 1'h0, 1, g1);
    join
    check("parallel grant cycle", g0, g1);
    fork
      access(0, 32'h00000010, 1'h1, 0, g0);
      access(1, 32'h40000030, 1'h0, 1, g1);
    join
    check("parallel grant cycle ext", g0, g1);
    for (int k = 0; k < 2; k++) begin
      contend(32'h80000100, 2, w);
      check("fixed winner sram", 32'h1, w);
    end
    contend(32'hF0000100, 3, w);
    check("fixed winner peripheral", 32'h0, w);
    // After a contention the loser was served last, so each check first serves one master alone.
    access(0, 32'h40000300, 1'h0, 1, g0);
    contend(32'h40000100, 1, w);
    check("round robin after master 0", 32'h1, w);
    access(1, 32'h40000400, 1'h1, 1, g1);
    contend(32'h40000200, 1, w);
    check("round robin after master 1", 32'h0, w);
    do_reset(1'h1);
    mode_and_width(1'h1);
    access(0, 32'h40000040, 1'h1, 1, g0);
    access(1, 32'hC0000004, 1'h0, 0, g0);
    end_of_test();
  end

  // The full sequence needs a few hundred cycles; this bound is far above it.
  initial begin
    #(20 * 20000);
    error_cnt++;
    $display("FAIL watchdog expected finish seen timeout");
    end_of_test();
  end
endmodule
`default_nettype wire
